//--- design/mfp_top.v
// motor fault and protection supervisor: overload, auto reset, brake, phase checks
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "mfp_defs.vh"
// Overview of operation
// (RL1) overload select 0 disables supervision, 1 enables inverse-time protection; reset 1.
// (RL2) unity gain, 175% current trips overload fault after 2 minutes.
// (RL3) unity gain, 115% current trips overload fault after 80 minutes.
// (RL4) curve trip time is multiplied by gain, adjustable 0.10 to 10.00.
// (RL5) scaled trip time is limited between 10 seconds and 80 minutes.
// (RL6) trip time interpolates linearly between curve points, 145%=6 min, 155%=4 min.
// (RL7) pre-alarm asserts once accumulated overload exceeds trip time times coefficient.
// (RL8) larger warning coefficient makes the pre-alarm come later.
// (RL9) ground check enabled drives motor phases briefly after power-up.
// (RL10) braking unit runs when bus voltage reaches the brake start setting.
// (RL11) auto reset tried at most the set count, 0 to 20, then stays faulted.
// (RL12) select decides whether fault output acts during auto reset attempts.
// (RL13) auto reset waits the set interval, 0.1 s to 100.0 s, default 1.0 s.
// (RL14) units digit allows input phase loss, tens digit contactor protection.
// (RL15) output phase loss protection 0 reports no fault, 1 allows it.
// (RL16) accumulator clears while current stays at or below lowest overload level.
module mfp_top #(
  parameter [23:0] TICK_CYCLES = `MFP_TICK_CYCLES,
  parameter [15:0] GND_CHECK_TICKS = `MFP_GND_CHECK_TICKS,
  parameter [15:0] BRAKE_DEFAULT = `MFP_RST_BRAKE_VOLT
) (
  input wire I_CLK_SYS,
  input wire I_RST,
  input wire [7:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output wire [15:0] O_RDATA,
  input wire [11:0] I_MOTOR_CURRENT,
  input wire [15:0] I_BUS_VOLTAGE,
  input wire I_GROUND_SHORT,
  input wire I_OUT_PHASE_LOSS,
  input wire I_IN_PHASE_LOSS,
  input wire I_CONTACTOR_FAULT,
  output wire [7:0] O_FAULT_CODE,
  output wire O_FAULT_ACTIVE,
  output wire O_FAULT_RELAY,
  output wire O_OL_PREALARM,
  output wire O_BRAKE_ON,
  output wire O_MOTOR_OUTPUT_PHASES_DRIVE,
  output wire O_IRQ
);
  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;
  localparam [1:0] GS_PEND = 2'b00;
  localparam [1:0] GS_DRIVE = 2'b01;
  localparam [1:0] GS_DONE = 2'b10;

  reg [15:0] ol_sel_reg, ol_gain_reg, ol_coeff_reg, gnd_en_reg, brake_v_reg;
  reg [15:0] ar_count_reg, ar_out_sel_reg, ar_interval_reg, in_phase_reg, out_phase_reg;
  reg [15:0] rdata_reg, rdata_next, trip_limit_reg, trip_limit_next, warn_limit_reg;
  reg [15:0] ol_acc_reg, wait_reg, gnd_cnt_reg;
  reg [3:0] irq_en_reg, irq_sts_reg, sync1_reg, sync2_reg;
  reg [1:0] fault_state_reg, gnd_state_reg;
  reg [7:0] fault_code_reg, det_code;
  reg [4:0] retry_reg;
  reg prealarm_reg, brake_reg, det;

  wire [15:0] curve_time, wait_inc, fault_status;
  wire [31:0] trip_scaled, warn_scaled;
  wire [3:0] irq_events, irq_clear;
  wire tick, curve_over, ol_enable, ol_trip, prealarm_next, retries_left, wait_done;
  wire gnd_short_s, out_loss_s, in_loss_s, contactor_s, in_phase_allow, contactor_allow;
  wire manual_clear, ev_fault, ev_lock, ev_arst, ev_pre;

  mfp_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .o_tick(tick)
  );

  mfp_curve u_curve (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_current(I_MOTOR_CURRENT),
    .o_over(curve_over),
    .o_curve_time(curve_time)
  );

  // out-of-range writes are pulled to the nearest legal setting
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo) begin
        clamp16 = lo;
      end else if (v > hi) begin
        clamp16 = hi;
      end else begin
        clamp16 = v;
      end
    end
  endfunction

  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ol_sel_reg <= `MFP_RST_OL_SELECT;
      ol_gain_reg <= `MFP_RST_OL_GAIN;
      ol_coeff_reg <= `MFP_RST_OL_COEFF;
      gnd_en_reg <= `MFP_RST_GND_ENABLE;
      brake_v_reg <= BRAKE_DEFAULT;
      ar_count_reg <= `MFP_RST_AR_COUNT;
      ar_out_sel_reg <= `MFP_RST_AR_OUT_SEL;
      ar_interval_reg <= `MFP_RST_AR_INTERVAL;
      in_phase_reg <= `MFP_RST_IN_PHASE;
      out_phase_reg <= `MFP_RST_OUT_PHASE;
      irq_en_reg <= 4'h0;
    end else if (I_WR) begin
      case (I_ADDR)
        `MFP_ADDR_OL_SELECT: ol_sel_reg <= {15'h0000, I_WDATA[0]};
        `MFP_ADDR_OL_GAIN: ol_gain_reg <= clamp16(I_WDATA, `MFP_GAIN_MIN, `MFP_GAIN_MAX);
        `MFP_ADDR_OL_COEFF: ol_coeff_reg <= clamp16(I_WDATA, `MFP_COEFF_MIN, `MFP_COEFF_MAX);
        `MFP_ADDR_GND_ENABLE: gnd_en_reg <= {15'h0000, I_WDATA[0]};
        `MFP_ADDR_BRAKE_VOLT: brake_v_reg <= clamp16(I_WDATA, `MFP_BRAKE_MIN, `MFP_BRAKE_MAX);
        `MFP_ADDR_AR_COUNT: ar_count_reg <= clamp16(I_WDATA, 16'h0000, `MFP_AR_COUNT_MAX);
        `MFP_ADDR_AR_OUT_SEL: ar_out_sel_reg <= {15'h0000, I_WDATA[0]};
        `MFP_ADDR_AR_INTERVAL: begin
          ar_interval_reg <= clamp16(I_WDATA, `MFP_INTERVAL_MIN, `MFP_INTERVAL_MAX);
        end
        `MFP_ADDR_IN_PHASE: in_phase_reg <= clamp16(I_WDATA, 16'h0000, `MFP_IN_PHASE_MAX);
        `MFP_ADDR_OUT_PHASE: out_phase_reg <= {15'h0000, I_WDATA[0]};
        `MFP_ADDR_IRQ_ENABLE: irq_en_reg <= I_WDATA[3:0];
        default: ol_sel_reg <= ol_sel_reg;
      endcase
    end
  end

  assign fault_status = {retry_reg, prealarm_reg, (fault_state_reg == ST_HOLD),
    (fault_state_reg != ST_RUN), fault_code_reg};

  // unmapped and write-only addresses read as zero
  always @* begin
    rdata_next = 16'h0000;
    case (I_ADDR)
      `MFP_ADDR_OL_SELECT: rdata_next = ol_sel_reg;
      `MFP_ADDR_OL_GAIN: rdata_next = ol_gain_reg;
      `MFP_ADDR_OL_COEFF: rdata_next = ol_coeff_reg;
      `MFP_ADDR_GND_ENABLE: rdata_next = gnd_en_reg;
      `MFP_ADDR_BRAKE_VOLT: rdata_next = brake_v_reg;
      `MFP_ADDR_AR_COUNT: rdata_next = ar_count_reg;
      `MFP_ADDR_AR_OUT_SEL: rdata_next = ar_out_sel_reg;
      `MFP_ADDR_AR_INTERVAL: rdata_next = ar_interval_reg;
      `MFP_ADDR_IN_PHASE: rdata_next = in_phase_reg;
      `MFP_ADDR_OUT_PHASE: rdata_next = out_phase_reg;
      `MFP_ADDR_FAULT_STATUS: rdata_next = fault_status;
      `MFP_ADDR_IRQ_STATUS: rdata_next = {12'h000, irq_sts_reg};
      `MFP_ADDR_IRQ_ENABLE: rdata_next = {12'h000, irq_en_reg};
      `MFP_ADDR_OL_ACCUM: rdata_next = ol_acc_reg;
      default: rdata_next = 16'h0000;
    endcase
  end

  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= 16'h0000;
    end else if (I_RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign O_RDATA = rdata_reg;

  // fault pins are asynchronous to the control clock
  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {I_CONTACTOR_FAULT, I_IN_PHASE_LOSS, I_OUT_PHASE_LOSS, I_GROUND_SHORT};
      sync2_reg <= sync1_reg;
    end
  end
  assign gnd_short_s = sync2_reg[0];
  assign out_loss_s = sync2_reg[1];
  assign in_loss_s = sync2_reg[2];
  assign contactor_s = sync2_reg[3];

  // (RL1) overload enable
  assign ol_enable = ol_sel_reg[0];
  // (RL4) gain scaling
  assign trip_scaled = ({16'h0000, curve_time} * {16'h0000, ol_gain_reg}) / 32'h00000064;
  // (RL8) coefficient sets warning point
  assign warn_scaled = ({16'h0000, trip_limit_reg} * {16'h0000, ol_coeff_reg}) / 32'h00000064;

  always @* begin
    trip_limit_next = trip_scaled[15:0];
    // (RL5) trip time limits
    if (trip_scaled > {16'h0000, `MFP_TRIP_MAX}) begin
      trip_limit_next = `MFP_TRIP_MAX;
    end else if (trip_scaled < {16'h0000, `MFP_TRIP_MIN}) begin
      trip_limit_next = `MFP_TRIP_MIN;
    end
  end

  // accumulator counts 0.1 s ticks of uninterrupted overload
  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      trip_limit_reg <= `MFP_TRIP_MAX;
      warn_limit_reg <= `MFP_TRIP_MAX;
      ol_acc_reg <= 16'h0000;
      prealarm_reg <= 1'b0;
    end else begin
      trip_limit_reg <= trip_limit_next;
      warn_limit_reg <= warn_scaled[15:0];
      prealarm_reg <= prealarm_next;
      // (RL16) clear below overload
      if (!ol_enable || !curve_over || fault_state_reg != ST_RUN) begin
        ol_acc_reg <= 16'h0000;
      end else if (tick && ol_acc_reg != 16'hFFFF) begin
        ol_acc_reg <= ol_acc_reg + 16'h0001;
      end
    end
  end
  // (RL2) overload trip compare
  // (RL3) long-time trip compare
  assign ol_trip = ol_enable & curve_over & (ol_acc_reg >= trip_limit_reg);
  // (RL7) pre-alarm threshold
  assign prealarm_next = ol_enable & curve_over & (ol_acc_reg > warn_limit_reg);
  assign O_OL_PREALARM = prealarm_reg;

  // (RL10) brake start compare
  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      brake_reg <= 1'b0;
    end else begin
      brake_reg <= (I_BUS_VOLTAGE >= brake_v_reg);
    end
  end
  assign O_BRAKE_ON = brake_reg;

  // the enable is looked at once, in the first cycle after reset release
  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      gnd_state_reg <= GS_PEND;
      gnd_cnt_reg <= 16'h0000;
    end else begin
      case (gnd_state_reg)
        GS_PEND: begin
          // (RL9) start ground check
          gnd_state_reg <= gnd_en_reg[0] ? GS_DRIVE : GS_DONE;
          gnd_cnt_reg <= 16'h0000;
        end
        GS_DRIVE: begin
          if (tick) begin
            gnd_cnt_reg <= gnd_cnt_reg + 16'h0001;
            if (gnd_cnt_reg + 16'h0001 >= GND_CHECK_TICKS) begin
              gnd_state_reg <= GS_DONE;
            end
          end
        end
        GS_DONE: gnd_state_reg <= GS_DONE;
        default: gnd_state_reg <= GS_DONE;
      endcase
    end
  end
  assign O_MOTOR_OUTPUT_PHASES_DRIVE = (gnd_state_reg == GS_DRIVE);

  // (RL14) digit decode
  assign in_phase_allow = ((in_phase_reg % 16'h000A) == 16'h0001);
  assign contactor_allow = (((in_phase_reg / 16'h000A) % 16'h000A) == 16'h0001);

  // fixed priority when several causes appear together
  always @* begin
    det = 1'b1;
    det_code = `MFP_CODE_NONE;
    if (O_MOTOR_OUTPUT_PHASES_DRIVE && gnd_short_s) begin
      det_code = `MFP_CODE_GROUND;
    // (RL15) output phase loss gate
    end else if (out_phase_reg[0] && out_loss_s) begin
      det_code = `MFP_CODE_OUT_PHASE;
    end else if (in_phase_allow && in_loss_s) begin
      det_code = `MFP_CODE_IN_PHASE;
    end else if (contactor_allow && contactor_s) begin
      det_code = `MFP_CODE_CONTACTOR;
    end else if (ol_trip) begin
      det_code = `MFP_CODE_OVERLOAD;
    end else begin
      det = 1'b0;
    end
  end

  // (RL11) retry budget
  assign retries_left = ({11'h000, retry_reg} < ar_count_reg);
  assign wait_inc = wait_reg + 16'h0001;
  // (RL13) tick phase is free, so one extra tick keeps the wait never short
  assign wait_done = tick & (wait_reg >= ar_interval_reg);
  assign manual_clear = I_WR & (I_ADDR == `MFP_ADDR_CTRL) & I_WDATA[0];
  assign ev_fault = det & (fault_state_reg == ST_RUN);
  assign ev_lock = ev_fault & ~retries_left;
  assign ev_arst = (fault_state_reg == ST_WAIT) & wait_done & ~manual_clear;
  assign ev_pre = prealarm_next & ~prealarm_reg;

  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      fault_state_reg <= ST_RUN;
      fault_code_reg <= `MFP_CODE_NONE;
      retry_reg <= 5'h00;
      wait_reg <= 16'h0000;
    end else begin
      case (fault_state_reg)
        ST_RUN: begin
          wait_reg <= 16'h0000;
          if (manual_clear) begin
            retry_reg <= 5'h00;
          end
          if (ev_fault) begin
            fault_code_reg <= det_code;
            fault_state_reg <= retries_left ? ST_WAIT : ST_HOLD;
          end
        end
        ST_WAIT: begin
          if (manual_clear) begin
            fault_state_reg <= ST_RUN;
            fault_code_reg <= `MFP_CODE_NONE;
            retry_reg <= 5'h00;
          end else if (wait_done) begin
            fault_state_reg <= ST_RUN;
            fault_code_reg <= `MFP_CODE_NONE;
            retry_reg <= retry_reg + 5'h01;
          end else if (tick) begin
            wait_reg <= wait_inc;
          end
        end
        ST_HOLD: begin
          // (RL11) locked until software clears
          if (manual_clear) begin
            fault_state_reg <= ST_RUN;
            fault_code_reg <= `MFP_CODE_NONE;
            retry_reg <= 5'h00;
          end
        end
        default: fault_state_reg <= ST_RUN;
      endcase
    end
  end
  assign O_FAULT_CODE = fault_code_reg;
  assign O_FAULT_ACTIVE = (fault_state_reg != ST_RUN);
  // (RL12) relay during auto reset
  assign O_FAULT_RELAY = (fault_state_reg == ST_HOLD) |
    ((fault_state_reg == ST_WAIT) & ar_out_sel_reg[0]);

  // a new event outranks a clear written in the same cycle
  assign irq_events = {ev_lock, ev_arst, ev_pre, ev_fault};
  assign irq_clear = (I_WR && I_ADDR == `MFP_ADDR_IRQ_CLEAR) ? I_WDATA[3:0] : 4'h0;
  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      irq_sts_reg <= 4'h0;
    end else begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clear) | irq_events;
    end
  end
  assign O_IRQ = |(irq_sts_reg & irq_en_reg);
endmodule // mfp_top

//--- inc/mfp_defs.vh
// constants shared by the motor fault protection manager files
`ifndef MFP_DEFS_VH
`define MFP_DEFS_VH
`define MFP_ADDR_OL_SELECT 8'h00
`define MFP_ADDR_OL_GAIN 8'h01
`define MFP_ADDR_OL_COEFF 8'h02
`define MFP_ADDR_GND_ENABLE 8'h07
`define MFP_ADDR_BRAKE_VOLT 8'h08
`define MFP_ADDR_AR_COUNT 8'h09
`define MFP_ADDR_AR_OUT_SEL 8'h0A
`define MFP_ADDR_AR_INTERVAL 8'h0B
`define MFP_ADDR_IN_PHASE 8'h0C
`define MFP_ADDR_OUT_PHASE 8'h0D
`define MFP_ADDR_CTRL 8'h10
`define MFP_ADDR_FAULT_STATUS 8'h11
`define MFP_ADDR_IRQ_STATUS 8'h12
`define MFP_ADDR_IRQ_CLEAR 8'h13
`define MFP_ADDR_IRQ_ENABLE 8'h14
`define MFP_ADDR_OL_ACCUM 8'h15
`define MFP_RST_OL_SELECT 16'h0001
`define MFP_RST_OL_GAIN 16'h0064
`define MFP_RST_OL_COEFF 16'h0050
`define MFP_RST_GND_ENABLE 16'h0001
`define MFP_RST_BRAKE_VOLT 16'h1B58
`define MFP_RST_AR_COUNT 16'h0000
`define MFP_RST_AR_OUT_SEL 16'h0000
`define MFP_RST_AR_INTERVAL 16'h000A
`define MFP_RST_IN_PHASE 16'h000B
`define MFP_RST_OUT_PHASE 16'h0001
`define MFP_GAIN_MIN 16'h000A
`define MFP_GAIN_MAX 16'h03E8
`define MFP_COEFF_MIN 16'h0032
`define MFP_COEFF_MAX 16'h0064
`define MFP_BRAKE_MIN 16'h07D0
`define MFP_BRAKE_MAX 16'h4E20
`define MFP_AR_COUNT_MAX 16'h0014
`define MFP_INTERVAL_MIN 16'h0001
`define MFP_INTERVAL_MAX 16'h03E8
`define MFP_IN_PHASE_MAX 16'h000B
`define MFP_TRIP_MAX 16'hBB80
`define MFP_TRIP_MIN 16'h0064
`define MFP_CUR_P0 12'h47E
`define MFP_CUR_P1 12'h4E2
`define MFP_CUR_P2 12'h5AA
`define MFP_CUR_P3 12'h60E
`define MFP_CUR_P4 12'h6D6
`define MFP_TIME_T0 16'hBB80
`define MFP_TIME_T1 16'h5DC0
`define MFP_TIME_T2 16'h0E10
`define MFP_TIME_T3 16'h0960
`define MFP_TIME_T4 16'h04B0
`define MFP_CODE_NONE 8'h00
`define MFP_CODE_OVERLOAD 8'h0B
`define MFP_CODE_IN_PHASE 8'h0C
`define MFP_CODE_OUT_PHASE 8'h0D
`define MFP_CODE_CONTACTOR 8'h11
`define MFP_CODE_GROUND 8'h14
`define MFP_IRQ_FAULT 0
`define MFP_IRQ_PREALARM 1
`define MFP_IRQ_AUTO_RESET 2
`define MFP_IRQ_LOCKED 3
`define MFP_TICK_CYCLES 24'h989680
`define MFP_GND_CHECK_TICKS 16'h0005
`endif

//--- design/mfp_tick.v
// periodic one-cycle tick used as the 0.1 s time base
`timescale 1ns/1ps
module mfp_tick #(
  parameter [23:0] DIV = 24'h989680
) (
  input wire i_clk,
  input wire i_rst,
  output reg o_tick
);
  reg [23:0] cnt_reg;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 24'h000000;
      o_tick <= 1'b0;
    end else if (cnt_reg >= DIV - 24'h000001) begin
      cnt_reg <= 24'h000000;
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 24'h000001;
      o_tick <= 1'b0;
    end
  end
endmodule // mfp_tick

//--- design/mfp_curve.v
// inverse-time overload curve lookup with linear interpolation
`timescale 1ns/1ps
`include "mfp_defs.vh"
module mfp_curve (
  input wire i_clk,
  input wire i_rst,
  input wire [11:0] i_current,
  output reg o_over,
  output reg [15:0] o_curve_time
);
  reg over_next;
  reg [15:0] time_next;
  // times fall with current, so the slope term is subtracted from the lower point
  function [15:0] interp;
    input [11:0] c;
    input [11:0] p_lo;
    input [11:0] p_hi;
    input [15:0] t_lo;
    input [15:0] t_hi;
    reg [31:0] dt;
    reg [31:0] dc;
    reg [31:0] step;
    begin
      dt = {16'h0000, t_lo} - {16'h0000, t_hi};
      dc = {20'h00000, c} - {20'h00000, p_lo};
      step = (dt * dc) / ({20'h00000, p_hi} - {20'h00000, p_lo});
      interp = t_lo - step[15:0];
    end
  endfunction
  always @* begin
    over_next = 1'b1;
    time_next = `MFP_TIME_T4;
    // (RL16) no overload level
    if (i_current <= `MFP_CUR_P0) begin
      over_next = 1'b0;
      time_next = `MFP_TIME_T0;
    // (RL6) interpolate between points
    end else if (i_current <= `MFP_CUR_P1) begin
      time_next = interp(i_current, `MFP_CUR_P0, `MFP_CUR_P1, `MFP_TIME_T0, `MFP_TIME_T1);
    end else if (i_current <= `MFP_CUR_P2) begin
      time_next = interp(i_current, `MFP_CUR_P1, `MFP_CUR_P2, `MFP_TIME_T1, `MFP_TIME_T2);
    end else if (i_current <= `MFP_CUR_P3) begin
      time_next = interp(i_current, `MFP_CUR_P2, `MFP_CUR_P3, `MFP_TIME_T2, `MFP_TIME_T3);
    end else if (i_current <= `MFP_CUR_P4) begin
      time_next = interp(i_current, `MFP_CUR_P3, `MFP_CUR_P4, `MFP_TIME_T3, `MFP_TIME_T4);
    end
  end
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_over <= 1'b0;
      o_curve_time <= `MFP_TIME_T0;
    end else begin
      o_over <= over_next;
      o_curve_time <= time_next;
    end
  end
endmodule // mfp_curve

//--- testbench/mfp_top_asserts.sv
// port checks for the motor fault protection manager
`timescale 1ns/1ps
module mfp_top_asserts #(
  parameter [23:0] TICK_CYCLES = 24'h4,
  parameter [15:0] GND_CHECK_TICKS = 16'h2
) (
  input wire I_CLK_SYS,
  input wire I_RST,
  input wire [11:0] I_MOTOR_CURRENT,
  input wire [15:0] I_BUS_VOLTAGE,
  input wire [7:0] O_FAULT_CODE,
  input wire O_FAULT_ACTIVE,
  input wire O_FAULT_RELAY,
  input wire O_OL_PREALARM,
  input wire O_BRAKE_ON,
  input wire O_MOTOR_OUTPUT_PHASES_DRIVE
);
  localparam [31:0] MIN_OVL = 32'h63 * TICK_CYCLES;
  localparam [31:0] DRV_MAX = (GND_CHECK_TICKS + 16'h2) * TICK_CYCLES + 32'h4;
  reg [31:0] up_reg;
  reg [31:0] ovl_reg;
  // cycles of unbroken overload
  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      up_reg <= 32'h0;
      ovl_reg <= 32'h0;
    end else begin
      up_reg <= up_reg + {31'h0, ~&up_reg};
      ovl_reg <= (I_MOTOR_CURRENT <= 12'h47E || O_FAULT_ACTIVE) ? 32'h0 : ovl_reg + 32'h1;
    end
  end
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  chk_brake_low: assert property
    ((!$past(I_RST) && $past(I_BUS_VOLTAGE) < 16'h07D0) |-> !O_BRAKE_ON) else $error("brake low");
  chk_brake_high: assert property
    ((!$past(I_RST) && $past(I_BUS_VOLTAGE) >= 16'h4E20) |-> O_BRAKE_ON) else $error("brake high");
  chk_relay_fault: assert property (O_FAULT_RELAY |-> O_FAULT_ACTIVE)
    else $error("relay without fault");
  chk_code_active: assert property (O_FAULT_ACTIVE |-> O_FAULT_CODE != 8'h00)
    else $error("fault without code");
  chk_fault_holds: assert property ($rose(O_FAULT_ACTIVE) |=> O_FAULT_ACTIVE[*3])
    else $error("fault cleared too soon");
  chk_calm_no_alarm: assert property
    ((I_MOTOR_CURRENT <= 12'h47E)[*3] |=> !O_OL_PREALARM) else $error("alarm on calm motor");
  chk_alarm_cause: assert property
    ($rose(O_OL_PREALARM) |-> $past(I_MOTOR_CURRENT, 2) > 12'h47E) else $error("alarm no load");
  chk_drive_window: assert property (O_MOTOR_OUTPUT_PHASES_DRIVE |-> up_reg < DRV_MAX)
    else $error("phases driven too long");
  chk_min_trip: assert property
    (($rose(O_FAULT_ACTIVE) && O_FAULT_CODE == 8'h0B) |-> ovl_reg >= MIN_OVL)
    else $error("overload trip too early");
endmodule // mfp_top_asserts

bind mfp_top mfp_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .GND_CHECK_TICKS(GND_CHECK_TICKS))
  u_mfp_top_asserts (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_MOTOR_CURRENT(I_MOTOR_CURRENT),
  .I_BUS_VOLTAGE(I_BUS_VOLTAGE), .O_FAULT_CODE(O_FAULT_CODE), .O_FAULT_ACTIVE(O_FAULT_ACTIVE),
  .O_FAULT_RELAY(O_FAULT_RELAY), .O_OL_PREALARM(O_OL_PREALARM), .O_BRAKE_ON(O_BRAKE_ON),
  .O_MOTOR_OUTPUT_PHASES_DRIVE(O_MOTOR_OUTPUT_PHASES_DRIVE));

//--- testbench/mfp_motor.sv
// behavioural motor and power stage feeding the drive's sense inputs
`timescale 1ns/1ps
module mfp_motor (
  input wire i_clk,
  input wire [11:0] i_cur_cmd,
  input wire [15:0] i_volt_cmd,
  input wire [7:0] i_lag,
  input wire i_short,
  input wire [2:0] i_loss,
  input wire i_driven,
  output reg [11:0] o_current,
  output reg [15:0] o_volt,
  output wire o_ground_short,
  output wire o_loss_out,
  output wire o_loss_in,
  output wire o_contactor
);
  reg [7:0] lag_reg = 8'h00;
  initial o_current = 12'h000;
  initial o_volt = 16'h0000;
  // load and bus settle i_lag+1 cycles after the command changes
  always @(posedge i_clk) begin
    if (o_current == i_cur_cmd && o_volt == i_volt_cmd) begin
      lag_reg <= 8'h00;
    end else if (lag_reg >= i_lag) begin
      o_current <= i_cur_cmd;
      o_volt <= i_volt_cmd;
      lag_reg <= 8'h00;
    end else begin
      lag_reg <= lag_reg + 8'h01;
    end
  end
  // a short to ground only shows while the phases carry voltage
  assign o_ground_short = i_short & i_driven;
  assign o_loss_out = i_loss[0];
  assign o_loss_in = i_loss[1];
  assign o_contactor = i_loss[2];
endmodule // mfp_motor

//--- testbench/test_motor_fault_protection_manager.sv
// self-checking bench for the motor fault protection manager
`timescale 1ns/1ps
module test_motor_fault_protection_manager;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg [11:0] cur_cmd = 12'h3E8;
  reg [15:0] volt_cmd = 16'h0000;
  reg [7:0] lag = 8'h00;
  reg short_cmd = 1'b1;
  reg [2:0] loss = 3'h0;
  reg [15:0] d;
  reg [31:0] s;
  wire [15:0] rdata, volt;
  wire [11:0] cur;
  wire [7:0] code;
  wire gnd, oloss, iloss, cfault, act, relay, pre, brake, drv, irq;
  integer n_fail, samples_checked, k, fc, pc, lim;
  integer cp [0:4] = '{1150, 1250, 1450, 1550, 1750};
  integer ct [0:4] = '{48000, 24000, 3600, 2400, 1200};
  integer oc [0:3] = '{1750, 1500, 1750, 1160};
  integer og [0:3] = '{10, 10, 100, 10};
  integer oq [0:3] = '{80, 50, 100, 80};
  reg [15:0] ra [0:10] = '{16'h0, 16'h1, 16'h2, 16'h7, 16'h8, 16'h9, 16'hA, 16'hB, 16'hC,
    16'hD, 16'h20};
  reg [15:0] rv [0:10] = '{16'h1, 16'h64, 16'h50, 16'h1, 16'h1B58, 16'h0, 16'h0, 16'hA,
    16'hB, 16'h1, 16'h0};
  reg [15:0] ca [0:5] = '{16'h1, 16'h2, 16'h8, 16'h9, 16'hB, 16'hC};
  reg [15:0] cw [0:5] = '{16'h1, 16'hFFFF, 16'h0, 16'h63, 16'h0, 16'hFF};
  reg [15:0] ce [0:5] = '{16'hA, 16'h64, 16'h7D0, 16'h14, 16'h1, 16'hB};
  reg [15:0] pa [0:2] = '{16'hD, 16'hC, 16'hC};
  reg [15:0] pf [0:2] = '{16'h0, 16'hA, 16'h1};
  reg [15:0] pn [0:2] = '{16'h1, 16'hB, 16'hB};
  reg [15:0] pk [0:2] = '{16'hD, 16'hC, 16'h11};
  always #5 clk = ~clk;
  mfp_top #(.TICK_CYCLES(24'h4), .GND_CHECK_TICKS(16'h2)) u_mfp_top (.I_CLK_SYS(clk),
    .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
    .I_MOTOR_CURRENT(cur), .I_BUS_VOLTAGE(volt), .I_GROUND_SHORT(gnd),
    .I_OUT_PHASE_LOSS(oloss), .I_IN_PHASE_LOSS(iloss), .I_CONTACTOR_FAULT(cfault),
    .O_FAULT_CODE(code), .O_FAULT_ACTIVE(act), .O_FAULT_RELAY(relay), .O_OL_PREALARM(pre),
    .O_BRAKE_ON(brake), .O_MOTOR_OUTPUT_PHASES_DRIVE(drv), .O_IRQ(irq));
  mfp_motor u_mfp_motor (.i_clk(clk), .i_cur_cmd(cur_cmd), .i_volt_cmd(volt_cmd), .i_lag(lag),
    .i_short(short_cmd), .i_loss(loss), .i_driven(drv), .o_current(cur), .o_volt(volt),
    .o_ground_short(gnd), .o_loss_out(oloss), .o_loss_in(iloss), .o_contactor(cfault));
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // reference trip time in ticks
  function integer trip(input integer c, input integer g);
    integer i, t;
    begin
      t = 1200;
      for (i = 3; i >= 0; i = i - 1)
        if (c < cp[i + 1]) t = ct[i] + (ct[i + 1] - ct[i]) * (c - cp[i]) / (cp[i + 1] - cp[i]);
      t = t * g / 100;
      trip = t < 100 ? 100 : (t > 48000 ? 48000 : t);
    end
  endfunction
  task cmp(input string nm, input [15:0] e, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [15:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [15:0] v);
    begin
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
    end
  endtask
  task setcur(input [11:0] v);
    begin
      @(posedge clk);
      cur_cmd <= v;
      cyc(1);
    end
  endtask
  task clr;
    begin
      setcur(12'h3E8);
      wr(8'h13, 16'hF);
      wr(8'h10, 16'h1);
      cyc(2);
    end
  endtask
  // cycles to the fault and to the first pre-alarm
  task watch(input integer lmt, output integer f, output integer p);
    begin
      f = 0;
      p = 0;
      while (act !== 1'b1 && f < lmt) begin
        cyc(1);
        f = f + 1;
        if (pre === 1'b1 && p == 0) p = f;
      end
    end
  endtask
  task results;
    begin
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    n_fail = 0;
    samples_checked = 0;
    s = 32'h42C4;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    cmp("gnd_drive", 16'h1, 16'(drv));
    cyc(30);
    cmp("gnd_drive", 16'h0, 16'(drv));
    cmp("gnd_code", 16'h14, 16'(code));
    cmp("irq_masked", 16'h0, 16'(irq));
    wr(8'h14, 16'h1);
    cyc(1);
    cmp("irq_on", 16'h1, 16'(irq));
    short_cmd <= 1'b0;
    clr;
    cmp("irq_off", 16'h0, 16'(irq));
    cmp("gnd_clear", 16'h0, 16'(code));
    for (k = 0; k < 11; k = k + 1) begin
      rd(ra[k][7:0], d);
      cmp("reset_val", rv[k], d);
    end
    for (k = 0; k < 6; k = k + 1) begin
      wr(ca[k][7:0], cw[k]);
      rd(ca[k][7:0], d);
      cmp("clamp", ce[k], d);
    end
    wr(8'h08, 16'h1000);
    for (k = 0; k < 8; k = k + 1) begin
      s = lfsr(s);
      @(posedge clk);
      volt_cmd <= (k == 7) ? 16'h4E20 : {3'h0, s[12:0]};
      lag <= {4'h0, s[19:16]};
      cyc(2);
      while (volt !== volt_cmd) cyc(1);
      cyc(2);
      cmp("brake", 16'(volt_cmd >= 16'h1000), 16'(brake));
    end
    lag <= 8'h00;
    for (k = 0; k < 4; k = k + 1) begin
      wr(8'h01, og[k]);
      wr(8'h02, oq[k]);
      lim = trip(oc[k], og[k]);
      setcur(oc[k]);
      watch(lim * 4 + 40, fc, pc);
      cmp("trip_ticks", lim, (fc + 1) / 4);
      cmp("alarm_ticks", oq[k] == 100 ? 0 : lim * oq[k] / 100 + 1, (pc + 1) / 4);
      cmp("ol_code", 16'hB, 16'(code));
      cmp("irq_fault", 16'h1, 16'(irq));
      clr;
    end
    wr(8'h00, 16'h0);
    setcur(12'h6D6);
    cyc(600);
    cmp("ol_off", 16'h0, 16'(act));
    clr;
    wr(8'h00, 16'h1);
    wr(8'h09, 16'h1);
    wr(8'h0A, 16'h1);
    wr(8'h0B, 16'h5);
    setcur(12'h6D6);
    watch(500, fc, pc);
    cmp("wait_relay", 16'h1, 16'(relay));
    fc = 0;
    while (act === 1'b1 && fc < 200) begin
      cyc(1);
      fc = fc + 1;
    end
    cmp("retry_ticks", 16'h5, (fc - 1) / 4);
    watch(500, fc, pc);
    cyc(40);
    rd(8'h11, d);
    cmp("locked", 16'h0B0B, d);
    clr;
    wr(8'h09, 16'h0);
    for (k = 0; k < 3; k = k + 1) begin
      wr(pa[k][7:0], pf[k]);
      loss <= 3'h1 << k;
      cyc(20);
      cmp("loss_off", 16'h0, 16'(code));
      wr(pa[k][7:0], pn[k]);
      cyc(20);
      cmp("loss_on", pk[k], 16'(code));
      loss <= 3'h0;
      clr;
    end
    results;
  end
  // the whole sequence needs roughly 30000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_fail = n_fail + 1;
    results;
  end
endmodule // test_motor_fault_protection_manager
